// *** include/rmc_consts.vh ***
`ifndef RMC_CONSTS_VH
`define RMC_CONSTS_VH

// serial command bus
`define RMC_DEV_ADDR 8'hE8
`define RMC_FRAME_BITS 5'h10
`define RMC_CMD_SYS 4'h1
`define RMC_CMD_MCLK 4'h2
`define RMC_CMD_RCLK 4'h3

// field positions, system setting word
`define RMC_SYS_VAL_SEL 1
`define RMC_SYS_EXT_IND 2
`define RMC_SYS_LIM_LO 4
`define RMC_SYS_LIM_HI 5

// field positions, master clock word
`define RMC_MC_LOCK_MUL 0
`define RMC_MC_XTAL_FREQ 1
`define RMC_MC_XDIV_LO 2
`define RMC_MC_XDIV_HI 3
`define RMC_MC_VCO_STOP 4
`define RMC_MC_EXT_SYNC 5
`define RMC_MC_AMP_LO 6
`define RMC_MC_AMP_HI 7

// field positions, receive output clock word
`define RMC_RC_PDIV_LO 0
`define RMC_RC_PDIV_HI 1
`define RMC_RC_XDIV_LO 2
`define RMC_RC_XDIV_HI 3
`define RMC_RC_BCK_LO 4
`define RMC_RC_BCK_HI 5
`define RMC_RC_LR_LO 6
`define RMC_RC_LR_HI 7

// reset values
`define RMC_SYS_RST 8'h00
`define RMC_MCLK_RST 8'h00
`define RMC_RCLK_RST 8'h00

// two-bit codes
`define RMC_AMP_AUTO 2'h0
`define RMC_AMP_CONT 2'h1
`define RMC_AMP_RSVD 2'h2
`define RMC_AMP_STOP 2'h3
`define RMC_LIM_NONE 2'h0
`define RMC_LIM_96K 2'h1
`define RMC_LIM_48K 2'h2
`define RMC_CODE_MUTE 2'h3

// divide ratios as log2, crystal at base frequency
`define RMC_BCK_BASE_LOG2 3'h2
`define RMC_LR_BASE_LOG2 4'h8

`endif

// *** tb/rmc_master_clock_config_chk.sv ***
`timescale 1ns/1ps
// ****************************
// port checker
// ****************************
module rmc_master_clock_config_chk
(
	input logic i_sys_clk,
	input logic i_rst_n,
	input logic i_pll_locked,
	input logic i_rate_changed,
	input logic i_cs_rate_changed,
	input logic [1:0] i_transmit_bit_clock_rate,
	input logic [1:0] i_transmit_master_div,
	input logic [1:0] o_oscillator_amp_mode,
	input logic o_amp_run,
	input logic o_rate_calc_req,
	input logic o_receive_error_force,
	input logic [2:0] o_xtal_mclk_log2,
	input logic o_xtal_mclk_mute,
	input logic [2:0] o_xtal_bck_log2,
	input logic o_xtal_bck_mute,
	input logic [1:0] o_transmit_bit_clock_eff
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	property p_calc_cont;
		o_oscillator_amp_mode == 2'h1 && $past(i_rst_n)
		|-> o_rate_calc_req == $past(i_rate_changed | i_cs_rate_changed);
	endproperty
	a_calc_cont: assert property (p_calc_cont) else $error("run mode rate request");
	property p_calc_cs;
		$past(i_cs_rate_changed) && $past(i_rst_n) |-> o_rate_calc_req;
	endproperty
	a_calc_cs: assert property (p_calc_cs) else $error("status change not calculated");
	property p_calc_auto;
		o_oscillator_amp_mode == 2'h0 && !o_amp_run && !$past(o_amp_run)
		&& !$past(i_cs_rate_changed) |-> !o_rate_calc_req;
	endproperty
	a_calc_auto: assert property (p_calc_auto) else $error("calc with amp stopped");
	property p_amp_cont;
		o_oscillator_amp_mode == 2'h1 |-> o_amp_run;
	endproperty
	a_amp_cont: assert property (p_amp_cont) else $error("amp idle in run mode");
	property p_amp_stop;
		o_oscillator_amp_mode == 2'h3 |-> !o_amp_run;
	endproperty
	a_amp_stop: assert property (p_amp_stop) else $error("amp runs in stop mode");
	property p_amp_auto;
		o_oscillator_amp_mode == 2'h0 && $past(i_rst_n) |-> o_amp_run == !$past(i_pll_locked);
	endproperty
	a_amp_auto: assert property (p_amp_auto) else $error("auto stop wrong");
	property p_err_pulse;
		o_receive_error_force |=> !o_receive_error_force;
	endproperty
	a_err_pulse: assert property (p_err_pulse) else $error("error force too long");
	property p_err_cause;
		o_receive_error_force |-> ##[0:1] o_oscillator_amp_mode == 2'h1;
	endproperty
	a_err_cause: assert property (p_err_cause) else $error("error force without run");
	property p_bck_floor;
		!o_xtal_bck_mute && !o_xtal_mclk_mute |-> o_xtal_bck_log2 >= o_xtal_mclk_log2;
	endproperty
	a_bck_floor: assert property (p_bck_floor) else $error("bit clock above master");
	property p_tx_fall;
		$past(i_rst_n) && $past(i_transmit_bit_clock_rate) != 2'h3
		&& $past(i_transmit_master_div) != 2'h3
		|-> o_transmit_bit_clock_eff == (({1'b0, $past(i_transmit_master_div)}
		+ {1'b0, $past(i_transmit_bit_clock_rate)} > 3'h2) ? 2'h0 : $past(i_transmit_bit_clock_rate));
	endproperty
	a_tx_fall: assert property (p_tx_fall) else $error("transmit fallback wrong");
endmodule // rmc_master_clock_config_chk
bind rmc_master_clock_config rmc_master_clock_config_chk rmc_master_clock_config_chk_i (.*);

// *** tb/rmc_master_clock_config_test.sv ***
`timescale 1ns/1ps
module rmc_master_clock_config_test;
	logic i_sys_clk, i_rst_n, i_ser_clk, i_ser_data, i_ser_enable, i_pll_locked;
	logic i_rate_change_not_error, i_rate_changed, i_cs_rate_changed, i_rate_over_48k;
	logic i_burst_sync, i_nonpcm_sync, i_validity;
	logic [1:0] i_transmit_bit_clock_rate, i_transmit_master_div;
	wire i_chip_address_upper = 1'b1;
	wire i_chip_address_lower = 1'b0;
	logic i_rate_over_96k;
	wire i_cs_bit1 = 1'b0;
	logic o_lock_multiple_select, o_crystal_frequency_select, o_crystal_clock_output_mute;
	logic o_vco_stop, o_external_sync_demod, o_amp_run, o_receive_error_force;
	logic o_rate_calc_req, o_rate_accept, o_nonpcm_or_validity_pin, o_locked_mclk_mute;
	logic o_xtal_mclk_mute, o_xtal_bck_mute, o_xtal_lr_mute;
	logic [1:0] o_crystal_clock_output_log2, o_oscillator_amp_mode, o_transmit_bit_clock_eff;
	logic [2:0] o_locked_mclk_log2, o_xtal_mclk_log2, o_xtal_bck_log2;
	logic [3:0] o_xtal_lr_log2;
	logic [7:0] n_err = 8'h00;
	logic [7:0] n_calc = 8'h00;
	int err_count = 0;
	int tests_run = 0;
	rmc_master_clock_config rmc_master_clock_config_i (.*);
	rmc_mcu_model rmc_mcu_model_i (.i_sys_clk(i_sys_clk), .o_ser_clk(i_ser_clk),
		.o_ser_data(i_ser_data), .o_ser_enable(i_ser_enable));
	initial
	begin
		i_sys_clk = 1'b0;
		forever #20 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk)
	begin
		n_err <= n_err + o_receive_error_force;
		n_calc <= n_calc + o_rate_calc_req;
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task stop_test;
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wr(input logic [3:0] c, input logic [7:0] d);
		rmc_mcu_model_i.send(8'hE8, {d, c, 4'h2}, 16);
	endtask
	task pulse(input logic cs);
		@(negedge i_sys_clk);
		i_cs_rate_changed = cs;
		i_rate_changed = !cs;
		@(negedge i_sys_clk);
		i_cs_rate_changed = 1'b0;
		i_rate_changed = 1'b0;
		repeat (3) @(negedge i_sys_clk);
	endtask
	task t_master;
		wr(4'h2, 8'hF7);
		chk({o_lock_multiple_select, o_crystal_frequency_select, o_vco_stop}, 8'h07);
		chk({o_external_sync_demod, o_oscillator_amp_mode, o_amp_run}, 8'h0E);
		chk({o_crystal_clock_output_mute, o_crystal_clock_output_log2}, 8'h01);
		wr(4'h2, 8'h0C);
		chk({o_lock_multiple_select, o_crystal_clock_output_mute}, 8'h01);
		rmc_mcu_model_i.send(8'hE9, 16'hFF22, 16);
		rmc_mcu_model_i.send(8'hE8, 16'hFF21, 16);
		rmc_mcu_model_i.send(8'hE8, 16'hFF22, 15);
		chk({o_vco_stop, o_oscillator_amp_mode}, 8'h00);
	endtask
	task t_rclk;
		int k;
		logic [1:0] c;
		for (k = 0; k < 4; k++)
		begin
			c = k[1:0];
			wr(4'h3, {c, c, c, c});
			chk({o_locked_mclk_mute, o_xtal_mclk_mute, o_xtal_bck_mute, o_xtal_lr_mute},
				{4'h0, {4{c == 2'h3}}});
			if (c != 2'h3)
			begin
				chk(o_locked_mclk_log2, (c == 2'h0) ? 8'h01 : (c == 2'h1) ? 8'h00 : 8'h02);
				chk(o_xtal_mclk_log2, {6'h00, c});
				chk(o_xtal_bck_log2, (c == 2'h1) ? 8'h01 : 8'h02);
				chk(o_xtal_lr_log2, 8'h08 - c);
			end
		end
		wr(4'h2, 8'h02);
		wr(4'h3, 8'h10);
		chk({o_xtal_bck_log2, o_xtal_lr_log2}, 8'h29);
		wr(4'h3, 8'h24);
		chk(o_xtal_bck_log2, 8'h01);
		wr(4'h2, 8'h00);
	endtask
	task t_tx;
		int m;
		int b;
		for (m = 0; m < 3; m++)
			for (b = 0; b < 3; b++)
			begin
				@(negedge i_sys_clk);
				i_transmit_master_div = m[1:0];
				i_transmit_bit_clock_rate = b[1:0];
				repeat (2) @(negedge i_sys_clk);
				chk(o_transmit_bit_clock_eff, (m + b > 2) ? 8'h00 : b[7:0]);
			end
	endtask
	task t_err_calc;
		logic [7:0] e;
		i_pll_locked = 1'b1;
		e = n_err;
		wr(4'h2, 8'h40);
		chk(n_err - e, 8'h01);
		e = n_calc;
		pulse(1'b0);
		chk(n_calc - e, 8'h01);
		wr(4'h2, 8'h00);
		i_rate_change_not_error = 1'b1;
		e = n_err;
		wr(4'h2, 8'h40);
		chk(n_err - e, 8'h00);
		wr(4'h2, 8'h00);
		e = n_calc;
		pulse(1'b0);
		chk(n_calc - e, 8'h00);
		pulse(1'b1);
		chk(n_calc - e, 8'h01);
	endtask
	task t_sys;
		i_rate_over_48k = 1'b1;
		wr(4'h1, 8'h20);
		chk(o_rate_accept, 8'h00);
		i_rate_over_96k = 1'b1;
		wr(4'h1, 8'h10);
		chk(o_rate_accept, 8'h00);
		wr(4'h1, 8'h00);
		chk(o_rate_accept, 8'h01);
		i_burst_sync = 1'b1;
		wr(4'h1, 8'h04);
		chk(o_nonpcm_or_validity_pin, 8'h01);
		i_nonpcm_sync = 1'b1;
		wr(4'h1, 8'h06);
		chk(o_nonpcm_or_validity_pin, 8'h00);
	endtask
	initial
	begin
		#400000;
		err_count++;
		stop_test;
	end
	initial
	begin
		{i_rst_n, i_pll_locked, i_rate_change_not_error, i_rate_changed} = 4'h0;
		{i_cs_rate_changed, i_rate_over_48k, i_burst_sync, i_nonpcm_sync, i_validity} = 5'h00;
		{i_transmit_bit_clock_rate, i_transmit_master_div} = 4'h0;
		i_rate_over_96k = 1'b0;
		repeat (5) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		@(negedge i_sys_clk);
		chk({o_amp_run, o_rate_accept, o_vco_stop, o_external_sync_demod}, 8'h0C);
		chk({o_xtal_bck_log2, o_xtal_lr_log2}, 8'h28);
		chk(o_locked_mclk_log2, 8'h01);
		t_master;
		t_rclk;
		t_tx;
		t_err_calc;
		t_sys;
		stop_test;
	end
endmodule // rmc_master_clock_config_test

// *** tb/rmc_mcu_model.sv ***
`timescale 1ns/1ps
// ****************************
// serial command bus writer
// ****************************
module rmc_mcu_model
(
	input logic i_sys_clk,
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_ser_enable
);
	initial
	begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_ser_enable = 1'b0;
	end
	task bit_out(input logic b);
		@(negedge i_sys_clk);
		o_ser_clk = 1'b0;
		o_ser_data = b;
		repeat (2) @(negedge i_sys_clk);
		o_ser_clk = 1'b1;
		@(negedge i_sys_clk);
	endtask
	// clock stands low between frames; data has no pull-up, so it flips once released
	task send(input logic [7:0] a, input logic [15:0] w, input int nb);
		int k;
		for (k = 0; k < 8; k++)
			bit_out(a[k]);
		@(negedge i_sys_clk);
		o_ser_clk = 1'b0;
		o_ser_enable = 1'b1;
		for (k = 0; k < nb; k++)
			bit_out(w[k]);
		@(negedge i_sys_clk);
		o_ser_clk = 1'b0;
		o_ser_enable = 1'b0;
		o_ser_data = ~o_ser_data;
		repeat (4) @(negedge i_sys_clk);
	endtask
endmodule // rmc_mcu_model

// *** verilog/rmc_clk_decode.v ***
`timescale 1ns/1ps
`include "rmc_consts.vh"

// ************************************************************
// receive output clock ratio decode
// ************************************************************
// ratios are log2 dividers; crystal bit and lr clock ratios follow the crystal
// frequency select so that a doubled crystal keeps their nominal output rates.
module rmc_clk_decode
(
	input wire [7:0] i_rclk_word,
	input wire i_xtal_double,
	output wire [2:0] o_locked_mclk_log2,
	output wire o_locked_mclk_mute,
	output wire [2:0] o_xtal_mclk_log2,
	output wire o_xtal_mclk_mute,
	output wire [2:0] o_xtal_bck_log2,
	output wire o_xtal_bck_mute,
	output wire [3:0] o_xtal_lr_log2,
	output wire o_xtal_lr_mute
);
	wire [1:0] pdiv;
	wire [1:0] xdiv;
	wire [1:0] bck;
	wire [1:0] lr;
	wire bck_slow;
	wire [1:0] bck_eff;

	assign pdiv = i_rclk_word[`RMC_RC_PDIV_HI:`RMC_RC_PDIV_LO];
	assign xdiv = i_rclk_word[`RMC_RC_XDIV_HI:`RMC_RC_XDIV_LO];
	assign bck = i_rclk_word[`RMC_RC_BCK_HI:`RMC_RC_BCK_LO];
	assign lr = i_rclk_word[`RMC_RC_LR_HI:`RMC_RC_LR_LO];

	// locked: 00 half, 01 full, 10 quarter of the lock frequency
	assign o_locked_mclk_log2 = (pdiv == 2'h1) ? 3'h0 : ((pdiv == 2'h2) ? 3'h2 : 3'h1);
	assign o_locked_mclk_mute = (pdiv == `RMC_CODE_MUTE);

	// crystal master clock is a plain 1/1, 1/2, 1/4 of the crystal
	assign o_xtal_mclk_log2 = {1'b0, xdiv};
	assign o_xtal_mclk_mute = (xdiv == `RMC_CODE_MUTE);

	// master clock below bit clock falls back to the slowest bit clock
	// a doubled crystal doubles the master clock but not the bit clock, so the
	// crossover moves up by one divide step
	assign bck_slow = (({1'b0, xdiv} + {1'b0, bck}) > (3'h2 + {2'h0, i_xtal_double}));
	assign bck_eff = bck_slow ? 2'h0 : bck;
	assign o_xtal_bck_log2 = `RMC_BCK_BASE_LOG2 - {1'b0, bck_eff} + {2'h0, i_xtal_double};
	assign o_xtal_bck_mute = (bck == `RMC_CODE_MUTE);
	assign o_xtal_lr_log2 = `RMC_LR_BASE_LOG2 - {2'h0, lr} + {3'h0, i_xtal_double};
	assign o_xtal_lr_mute = (lr == `RMC_CODE_MUTE);
endmodule // rmc_clk_decode

// *** verilog/rmc_master_clock_config.v ***
`timescale 1ns/1ps
`include "rmc_consts.vh"

// Notes on behaviour
// - master clock word is command 2, device address E8; receive clock word command 3
// - command 3 carries lr, bit, crystal master and locked master clock fields
// - range limit 10 accepts only rates up to 48k; 11 is reserved
// - extended indicator acts only while the pin shows channel status bit 1
// - extended indicator drives pin high on burst sync, non-pcm sync or bit 1
// - vco stop bit: 0 runs the vco, 1 halts it
// - external sync bit demodulates without pll from a supplied 256fs clock
// - amplifier mode: 00 auto stop when locked, 01 run, 11 stop, 10 reserved
// - switching to continuous run while locked forces one error unless masked
// - auto stop: in-range rate change without lock error starts no rate calculation
// - auto stop: channel status rate change recalculates rate without forcing an error
// - continuous run: every rate change is calculated and flagged
// - locked master clock: 00 half, 01 full, 10 quarter, 11 muted
// - crystal master clock: 00 full, 01 half, 10 quarter, 11 muted
// - crystal bit clock: 3.072, 6.144, 12.288 MHz or muted
// - crystal lr clock: 48, 96, 192 kHz or muted
// - master clock slower than bit clock forces 3.072 MHz, transmit side too
module rmc_master_clock_config
(
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_ser_clk,
	input wire i_ser_data,
	input wire i_ser_enable,
	input wire i_chip_address_upper,
	input wire i_chip_address_lower,
	input wire i_pll_locked,
	input wire i_rate_change_not_error,
	input wire i_rate_changed,
	input wire i_cs_rate_changed,
	input wire i_rate_over_48k,
	input wire i_rate_over_96k,
	input wire i_cs_bit1,
	input wire i_burst_sync,
	input wire i_nonpcm_sync,
	input wire i_validity,
	input wire [1:0] i_transmit_bit_clock_rate,
	input wire [1:0] i_transmit_master_div,
	output reg o_lock_multiple_select,
	output reg o_crystal_frequency_select,
	output reg [1:0] o_crystal_clock_output_log2,
	output reg o_crystal_clock_output_mute,
	output reg o_vco_stop,
	output reg o_external_sync_demod,
	output reg [1:0] o_oscillator_amp_mode,
	output reg o_amp_run,
	output reg o_receive_error_force,
	output reg o_rate_calc_req,
	output reg o_rate_accept,
	output reg o_nonpcm_or_validity_pin,
	output reg [2:0] o_locked_mclk_log2,
	output reg o_locked_mclk_mute,
	output reg [2:0] o_xtal_mclk_log2,
	output reg o_xtal_mclk_mute,
	output reg [2:0] o_xtal_bck_log2,
	output reg o_xtal_bck_mute,
	output reg [3:0] o_xtal_lr_log2,
	output reg o_xtal_lr_mute,
	output reg [1:0] o_transmit_bit_clock_eff
);
	// ************************************************************
	// command reception
	// ************************************************************
	wire wr;
	wire [3:0] cmd;
	wire [1:0] chip;
	wire [7:0] data;
	wire hit;

	rmc_serial_rx u_rx
	(
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_ser_clk(i_ser_clk),
		.i_ser_data(i_ser_data),
		.i_ser_enable(i_ser_enable),
		.o_wr(wr),
		.o_cmd(cmd),
		.o_chip_addr(chip),
		.o_data(data)
	);

	assign hit = wr && chip == {i_chip_address_upper, i_chip_address_lower};

	// ************************************************************
	// command registers
	// ************************************************************
	// write only: software cannot read these back, so the master clock word
	// is mirrored onto outputs for the surrounding logic
	reg [7:0] sys_r;
	reg [7:0] mclk_r;
	reg [7:0] rclk_r;

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			sys_r <= `RMC_SYS_RST;
			mclk_r <= `RMC_MCLK_RST;
			rclk_r <= `RMC_RCLK_RST;
		end
		else if (hit)
		begin
			if (cmd == `RMC_CMD_SYS)
				sys_r <= data;
			if (cmd == `RMC_CMD_MCLK)
				mclk_r <= data;
			if (cmd == `RMC_CMD_RCLK)
				rclk_r <= data;
		end
	end

	wire [1:0] amp_mode;
	wire [1:0] xdiv;
	wire [1:0] lim;
	wire mode_to_cont;

	assign amp_mode = mclk_r[`RMC_MC_AMP_HI:`RMC_MC_AMP_LO];
	assign xdiv = mclk_r[`RMC_MC_XDIV_HI:`RMC_MC_XDIV_LO];
	assign lim = sys_r[`RMC_SYS_LIM_HI:`RMC_SYS_LIM_LO];
	// a write that moves the amplifier into continuous run
	assign mode_to_cont = hit && cmd == `RMC_CMD_MCLK
		&& data[`RMC_MC_AMP_HI:`RMC_MC_AMP_LO] == `RMC_AMP_CONT
		&& amp_mode != `RMC_AMP_CONT;

	// ************************************************************
	// clock ratio decode
	// ************************************************************
	wire [2:0] lm_log2;
	wire lm_mute;
	wire [2:0] xm_log2;
	wire xm_mute;
	wire [2:0] xb_log2;
	wire xb_mute;
	wire [3:0] xl_log2;
	wire xl_mute;

	rmc_clk_decode u_dec
	(
		.i_rclk_word(rclk_r),
		.i_xtal_double(mclk_r[`RMC_MC_XTAL_FREQ]),
		.o_locked_mclk_log2(lm_log2),
		.o_locked_mclk_mute(lm_mute),
		.o_xtal_mclk_log2(xm_log2),
		.o_xtal_mclk_mute(xm_mute),
		.o_xtal_bck_log2(xb_log2),
		.o_xtal_bck_mute(xb_mute),
		.o_xtal_lr_log2(xl_log2),
		.o_xtal_lr_mute(xl_mute)
	);

	// ************************************************************
	// amplifier, rate calculation and indicator pin
	// ************************************************************
	reg amp_run_nxt;
	reg calc_nxt;
	reg accept_nxt;
	reg pin_nxt;

	always @*
	begin
		case (amp_mode)
			`RMC_AMP_AUTO: amp_run_nxt = ~i_pll_locked;
			`RMC_AMP_CONT: amp_run_nxt = 1'b1;
			`RMC_AMP_STOP: amp_run_nxt = 1'b0;
			default: amp_run_nxt = ~i_pll_locked;
		endcase
		// status rate change always recalculates; a bare input change only
		// while the amplifier is running to measure it
		if (amp_mode == `RMC_AMP_CONT)
			calc_nxt = i_rate_changed | i_cs_rate_changed;
		else
			calc_nxt = i_cs_rate_changed | (i_rate_changed & amp_run_nxt);
		case (lim)
			`RMC_LIM_NONE: accept_nxt = 1'b1;
			`RMC_LIM_96K: accept_nxt = ~i_rate_over_96k;
			`RMC_LIM_48K: accept_nxt = ~i_rate_over_48k;
			default: accept_nxt = 1'b1;
		endcase
		if (sys_r[`RMC_SYS_VAL_SEL])
			pin_nxt = i_validity;
		else if (sys_r[`RMC_SYS_EXT_IND])
			pin_nxt = i_cs_bit1 | i_burst_sync | i_nonpcm_sync;
		else
			pin_nxt = i_cs_bit1;
	end

	// transmit bit clock fallback uses the receive comparison without the doubled crystal step
	wire tx_slow;
	assign tx_slow = i_transmit_master_div > (2'h2 - i_transmit_bit_clock_rate);

	// ************************************************************
	// output registers
	// ************************************************************
	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			o_lock_multiple_select <= 1'b0;
			o_crystal_frequency_select <= 1'b0;
			o_crystal_clock_output_log2 <= 2'h0;
			o_crystal_clock_output_mute <= 1'b0;
			o_vco_stop <= 1'b0;
			o_external_sync_demod <= 1'b0;
			o_oscillator_amp_mode <= 2'h0;
			o_amp_run <= 1'b1;
			o_receive_error_force <= 1'b0;
			o_rate_calc_req <= 1'b0;
			o_rate_accept <= 1'b1;
			o_nonpcm_or_validity_pin <= 1'b0;
			o_locked_mclk_log2 <= 3'h1;
			o_locked_mclk_mute <= 1'b0;
			o_xtal_mclk_log2 <= 3'h0;
			o_xtal_mclk_mute <= 1'b0;
			o_xtal_bck_log2 <= `RMC_BCK_BASE_LOG2;
			o_xtal_bck_mute <= 1'b0;
			o_xtal_lr_log2 <= `RMC_LR_BASE_LOG2;
			o_xtal_lr_mute <= 1'b0;
			o_transmit_bit_clock_eff <= 2'h0;
		end
		else
		begin
			o_lock_multiple_select <= mclk_r[`RMC_MC_LOCK_MUL];
			o_crystal_frequency_select <= mclk_r[`RMC_MC_XTAL_FREQ];
			// reserved code 10 is run as full rate rather than left undefined
			o_crystal_clock_output_log2 <= {1'b0, xdiv == 2'h1};
			o_crystal_clock_output_mute <= (xdiv == `RMC_CODE_MUTE);
			o_vco_stop <= mclk_r[`RMC_MC_VCO_STOP];
			o_external_sync_demod <= mclk_r[`RMC_MC_EXT_SYNC];
			o_oscillator_amp_mode <= amp_mode;
			o_amp_run <= amp_run_nxt;
			o_receive_error_force <= mode_to_cont & i_pll_locked & ~i_rate_change_not_error;
			o_rate_calc_req <= calc_nxt;
			o_rate_accept <= accept_nxt;
			o_nonpcm_or_validity_pin <= pin_nxt;
			o_locked_mclk_log2 <= lm_log2;
			o_locked_mclk_mute <= lm_mute;
			o_xtal_mclk_log2 <= xm_log2;
			o_xtal_mclk_mute <= xm_mute;
			o_xtal_bck_log2 <= xb_log2;
			o_xtal_bck_mute <= xb_mute;
			o_xtal_lr_log2 <= xl_log2;
			o_xtal_lr_mute <= xl_mute;
			o_transmit_bit_clock_eff <= (tx_slow && i_transmit_bit_clock_rate != `RMC_CODE_MUTE)
				? 2'h0 : i_transmit_bit_clock_rate;
		end
	end
endmodule // rmc_master_clock_config

// *** verilog/rmc_serial_rx.v ***
`timescale 1ns/1ps
`include "rmc_consts.vh"

// ************************************************************
// serial command receiver
// ************************************************************
// device address is shifted in lsb first while enable is low, then the
// sixteen command bits while enable is high; the frame is taken on the
// falling edge of enable only if exactly sixteen bits arrived.
module rmc_serial_rx
(
	input wire i_sys_clk,
	input wire i_rst_n,
	input wire i_ser_clk,
	input wire i_ser_data,
	input wire i_ser_enable,
	output reg o_wr,
	output reg [3:0] o_cmd,
	output reg [1:0] o_chip_addr,
	output reg [7:0] o_data
);
	reg clk_d_r;
	reg en_d_r;
	reg [7:0] addr_r;
	reg [15:0] shift_r;
	reg [4:0] cnt_r;
	wire rise;
	wire en_fall;

	assign rise = i_ser_clk & ~clk_d_r;
	assign en_fall = en_d_r & ~i_ser_enable;

	always @(posedge i_sys_clk)
	begin
		if (!i_rst_n)
		begin
			clk_d_r <= 1'b0;
			en_d_r <= 1'b0;
			addr_r <= 8'h00;
			shift_r <= 16'h0000;
			cnt_r <= 5'h00;
			o_wr <= 1'b0;
			o_cmd <= 4'h0;
			o_chip_addr <= 2'h0;
			o_data <= 8'h00;
		end
		else
		begin
			clk_d_r <= i_ser_clk;
			en_d_r <= i_ser_enable;
			o_wr <= 1'b0;
			if (!i_ser_enable && en_d_r)
				cnt_r <= 5'h00;
			else if (rise && i_ser_enable && cnt_r != 5'h1F)
				cnt_r <= cnt_r + 5'h01;
			if (rise && !i_ser_enable)
				addr_r <= {i_ser_data, addr_r[7:1]};
			if (rise && i_ser_enable)
				shift_r <= {i_ser_data, shift_r[15:1]};
			if (en_fall && cnt_r == `RMC_FRAME_BITS && addr_r == `RMC_DEV_ADDR)
			begin
				o_wr <= 1'b1;
				o_chip_addr <= shift_r[1:0];
				o_cmd <= shift_r[7:4];
				o_data <= shift_r[15:8];
			end
		end
	end
endmodule // rmc_serial_rx
